// ---- hw/tcp_pwm.sv ----
// Three-phase center-based PWM generator with APB registers
//
// What this block does
// - Six active-high outputs, three phase pairs of high and low drive.
// - 16-bit timing unit makes complementary center-based waves with dead time.
// - Half-period, dead time and minimum pulse width are separate settings.
// - Three independent 16-bit duty values, one per phase pair.
// - Half-period counts ticks in half a period; largest value 0xFFFF.
// - One tick is one clock period; single clock for everything.
// - Each output has its own enable; disabled output never goes active.
// - Per-phase crossover swaps high and low waveforms.
// - Outputs mixed with chopping signal, frequency from 8-bit gate value.
// - Chopping enabled separately for high-side and low-side outputs.
// - Single update mode takes new values once per period.
// - Double update mode also takes new values at period midpoint.
// - Mode control bit 6 selects single or double update.
// - Sync pulse at period start, extra one at midpoint in double mode.
// - Sync pulse width set by sync-width register.
// - Trip input low forces all outputs low without clocked logic.
// - Software trip write shuts outputs down like the pin.
// - Shutdown controller takes both trips and resets the timing unit.
// - Status shows trip input level and which period half runs.
// - One interrupt per sync pulse, another per shutdown event.
// - Mode bit 6 clear means single, set double; cleared after reset.
// - Dead time is value times two ticks; zero gives none.
// - Sync pulse lasts width plus one ticks; width resets to 0x27.
// - Status bit 3 clear in first half, set in second half.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tcp_pwm #(
	parameter int CNT_W = 16,
	parameter int DT_W = 10,
	parameter int CHOP_W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tripInN,
	output logic phaseAHighOut,
	output logic phaseALowOut,
	output logic phaseBHighOut,
	output logic phaseBLowOut,
	output logic phaseCHighOut,
	output logic phaseCLowOut,
	output logic periodSyncPulse,
	output logic syncIrq,
	output logic tripIrq
);
	localparam int SW = CNT_W + 3;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [CNT_W-1:0] tmQ, pdQ, tmA, pdA;
	logic [DT_W-1:0] dtQ, dtA;
	logic [7:0] swQ;
	logic [CNT_W-1:0] dutyQ [3];
	logic [CNT_W-1:0] dutyA [3];
	logic [8:0] segQ, segA;
	logic [9:0] gateQ;
	logic modeQ;
	logic tripS1Q, tripS2Q, shdnQ;
	logic [CNT_W-1:0] cntQ;
	logic halfQ;
	logic [31:0] rdD;
	logic mapped, wrEn;

	assign wrEn = psel && penable && pwrite && pready;

	always_comb begin
		rdD = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			tcp_pkg::OFF_HALF_PERIOD: rdD[CNT_W-1:0] = tmQ;
			tcp_pkg::OFF_DEAD_TIME: rdD[DT_W-1:0] = dtQ;
			tcp_pkg::OFF_MIN_PULSE: rdD[CNT_W-1:0] = pdQ;
			tcp_pkg::OFF_SYNC_WIDTH: rdD[7:0] = swQ;
			tcp_pkg::OFF_DUTY_A: rdD[CNT_W-1:0] = dutyQ[0];
			tcp_pkg::OFF_DUTY_B: rdD[CNT_W-1:0] = dutyQ[1];
			tcp_pkg::OFF_DUTY_C: rdD[CNT_W-1:0] = dutyQ[2];
			tcp_pkg::OFF_SEGMENT: rdD[8:0] = segQ;
			tcp_pkg::OFF_GATE_CHOP: rdD[9:0] = gateQ;
			tcp_pkg::OFF_MODE: rdD[tcp_pkg::MODE_DOUBLE_BIT] = modeQ;
			tcp_pkg::OFF_STATUS: begin
				rdD[tcp_pkg::STAT_TRIP_BIT] = tripS2Q;
				rdD[tcp_pkg::STAT_SHDN_BIT] = shdnQ;
				rdD[tcp_pkg::STAT_HALF_BIT] = halfQ;
			end
			tcp_pkg::OFF_SW_TRIP: rdD = 32'h0000_0000;
			default: mapped = 1'b0;
		endcase
	end

	// Answer is prepared in the setup cycle, so access never waits
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable) begin
				prdata <= rdD;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			tmQ <= tcp_pkg::RST_HALF_PERIOD;
			dtQ <= tcp_pkg::RST_DEAD_TIME;
			pdQ <= tcp_pkg::RST_MIN_PULSE;
			swQ <= tcp_pkg::RST_SYNC_WIDTH;
			dutyQ <= '{default: tcp_pkg::RST_DUTY};
			segQ <= tcp_pkg::RST_SEGMENT;
			gateQ <= tcp_pkg::RST_GATE_CHOP;
			modeQ <= 1'b0;
		end else if (wrEn) begin
			case (paddr)
				// separate period, dead time, pulse settings
				tcp_pkg::OFF_HALF_PERIOD: tmQ <= pwdata[CNT_W-1:0];
				tcp_pkg::OFF_DEAD_TIME: dtQ <= pwdata[DT_W-1:0];
				tcp_pkg::OFF_MIN_PULSE: pdQ <= pwdata[CNT_W-1:0];
				tcp_pkg::OFF_SYNC_WIDTH: swQ <= pwdata[7:0];
				tcp_pkg::OFF_DUTY_A: dutyQ[0] <= pwdata[CNT_W-1:0];
				tcp_pkg::OFF_DUTY_B: dutyQ[1] <= pwdata[CNT_W-1:0];
				tcp_pkg::OFF_DUTY_C: dutyQ[2] <= pwdata[CNT_W-1:0];
				tcp_pkg::OFF_SEGMENT: segQ <= pwdata[8:0];
				tcp_pkg::OFF_GATE_CHOP: gateQ <= pwdata[9:0];
				tcp_pkg::OFF_MODE: modeQ <= pwdata[tcp_pkg::MODE_DOUBLE_BIT];
				default: modeQ <= modeQ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Shutdown controller
	// ------------------------------------------------------------
	logic swTripWr, shdnSet, shdnClr, tripIrqQ;

	assign swTripWr = wrEn && paddr == tcp_pkg::OFF_SW_TRIP;
	assign shdnClr = wrEn && paddr == tcp_pkg::OFF_STATUS &&
		pwdata[tcp_pkg::STAT_SHDN_BIT] && tripS2Q;
	assign shdnSet = !tripS2Q || swTripWr;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			tripS1Q <= 1'b1;
			tripS2Q <= 1'b1;
		end else begin
			tripS1Q <= tripInN;
			tripS2Q <= tripS1Q;
		end
	end

	// A new trip in the clearing cycle keeps the block shut down
	always_ff @(posedge clk) begin
		if (!nrst) begin
			shdnQ <= 1'b0;
			tripIrqQ <= 1'b0;
		end else begin
			if (shdnSet) begin
				shdnQ <= 1'b1;
			end else if (shdnClr) begin
				shdnQ <= 1'b0;
			end
			tripIrqQ <= shdnSet && !shdnQ;
		end
	end

	// ------------------------------------------------------------
	// Timing unit
	// ------------------------------------------------------------
	logic periodStart, midPoint, syncStart;

	assign periodStart = halfQ && cntQ == '0 && !shdnQ;
	assign midPoint = !halfQ && ({1'b0, cntQ} + 1'b1 >= {1'b0, tmA}) &&
		!shdnQ;
	assign syncStart = periodStart || (midPoint && modeQ);

	// counter steps every clock except at the two turning points, where it holds, and is cleared to zero while shut down
	always_ff @(posedge clk) begin
		if (!nrst || shdnQ) begin
			cntQ <= '0;
			halfQ <= 1'b1;
		end else if (!halfQ) begin
			if (midPoint) begin
				halfQ <= 1'b1;
			end else begin
				cntQ <= cntQ + 1'b1;
			end
		end else if (cntQ == '0) begin
			halfQ <= 1'b0;
		end else begin
			cntQ <= cntQ - 1'b1;
		end
	end

	// Shadow values go live only at sync points
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tmA <= tcp_pkg::RST_HALF_PERIOD;
			dtA <= tcp_pkg::RST_DEAD_TIME;
			pdA <= tcp_pkg::RST_MIN_PULSE;
			dutyA <= '{default: tcp_pkg::RST_DUTY};
			segA <= tcp_pkg::RST_SEGMENT;
		end else if (syncStart) begin
			tmA <= tmQ;
			dtA <= dtQ;
			pdA <= pdQ;
			dutyA <= dutyQ;
			segA <= segQ;
		end
	end

	// ------------------------------------------------------------
	// Sync pulse
	// ------------------------------------------------------------
	logic [7:0] syncCntQ;
	logic syncQ, syncIrqQ;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			syncQ <= 1'b0;
			syncCntQ <= '0;
			syncIrqQ <= 1'b0;
		end else begin
			if (syncStart) begin
				syncQ <= 1'b1;
				syncCntQ <= swQ;
			end else if (syncQ && syncCntQ == '0) begin
				syncQ <= 1'b0;
			end else if (syncQ) begin
				syncCntQ <= syncCntQ - 1'b1;
			end
			syncIrqQ <= syncStart;
		end
	end

	// ------------------------------------------------------------
	// Gate chopping
	// ------------------------------------------------------------
	logic [CHOP_W-1:0] chopCntQ;
	logic chopQ;

	// chop toggles every value plus one ticks
	always_ff @(posedge clk) begin
		if (!nrst) begin
			chopCntQ <= '0;
			chopQ <= 1'b0;
		end else if (chopCntQ >= gateQ[CHOP_W-1:0]) begin
			chopCntQ <= '0;
			chopQ <= !chopQ;
		end else begin
			chopCntQ <= chopCntQ + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Waveforms and output control
	// ------------------------------------------------------------
	logic [5:0] waveD, outQ;

	for (genvar i = 0; i < 3; i++) begin : gPhase
		logic signed [SW-1:0] pos, tm, duty, dt, pd, hiOn, loOn;
		logic hiW, loW, hiX, loX;
		assign pos = $signed({3'b000, cntQ});
		assign tm = $signed({3'b000, tmA});
		assign duty = $signed({3'b000, dutyA[i]});
		assign dt = $signed({{(SW-DT_W){1'b0}}, dtA});
		assign pd = $signed({3'b000, pdA});
		assign hiOn = duty - dt;
		assign loOn = tm - duty - dt;
		// center-based edges moved apart by dead time
		assign hiW = pos >= tm - duty + dt && hiOn >= pd;
		assign loW = pos < loOn && loOn >= pd;
		assign hiX = segA[tcp_pkg::SEG_XOVER_LSB + i] ? loW : hiW;
		assign loX = segA[tcp_pkg::SEG_XOVER_LSB + i] ? hiW : loW;
		assign waveD[2*i] = hiX && segA[2*i] &&
			(!gateQ[tcp_pkg::GATE_HI_EN_BIT] || chopQ);
		assign waveD[2*i+1] = loX && segA[2*i+1] &&
			(!gateQ[tcp_pkg::GATE_LO_EN_BIT] || chopQ);
	end

	always_ff @(posedge clk) begin
		if (!nrst || shdnQ) begin
			outQ <= '0;
		end else begin
			outQ <= waveD;
		end
	end

	// trip pin gates outputs after the flops
	assign phaseAHighOut = outQ[0] && tripInN;
	assign phaseALowOut = outQ[1] && tripInN;
	assign phaseBHighOut = outQ[2] && tripInN;
	assign phaseBLowOut = outQ[3] && tripInN;
	assign phaseCHighOut = outQ[4] && tripInN;
	assign phaseCLowOut = outQ[5] && tripInN;
	assign periodSyncPulse = syncQ;
	assign syncIrq = syncIrqQ;
	assign tripIrq = tripIrqQ;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [8:0] lenQ;
	logic [7:0] wLoadQ;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			lenQ <= '0;
			wLoadQ <= '0;
		end else if (syncStart) begin
			lenQ <= 9'h001;
			wLoadQ <= swQ;
		end else if (syncQ) begin
			lenQ <= lenQ + 1'b1;
		end else begin
			lenQ <= '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_trip_forces_low: assert property (
		!tripInN |-> {phaseAHighOut, phaseALowOut, phaseBHighOut,
			phaseBLowOut, phaseCHighOut, phaseCLowOut} == 6'h00)
		else $error("outputs active while trip input low");
	chk_sync_width: assert property (
		$fell(syncQ) |-> $past(lenQ) == {1'b0, $past(wLoadQ)} + 9'h001)
		else $error("sync pulse width not width plus one");
	chk_half_flag: assert property (
		midPoint |=> halfQ ##1 (halfQ || periodStart))
		else $error("half flag not set in second half");
	chk_double_mid_sync: assert property (
		midPoint && modeQ |=> periodSyncPulse && syncIrq)
		else $error("no midpoint sync in double mode");
	chk_single_no_mid: assert property (
		midPoint && !modeQ && !syncQ |=> !periodSyncPulse)
		else $error("midpoint sync in single mode");
	chk_swtrip_shutdown: assert property (
		swTripWr |=> shdnQ ##1 outQ == 6'h00)
		else $error("software trip did not shut down");
	chk_trip_irq: assert property (
		$rose(shdnQ) |-> tripIrqQ)
		else $error("no interrupt on shutdown");
	chk_disabled_low: assert property (
		!segA[0] |=> !outQ[0])
		else $error("disabled output driven");
	chk_pair_exclusive: assert property (
		!(outQ[2] && outQ[3]))
		else $error("both outputs of a pair active");
	chk_latch_period: assert property (
		syncStart |=> tmA == $past(tmQ) && dutyA[1] == $past(dutyQ[1]))
		else $error("shadow values not taken at sync");
endmodule : tcp_pwm
`default_nettype wire

// ---- hw/tcp_pkg.sv ----
// Package: register map, field positions and reset values of the PWM block
package tcp_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_HALF_PERIOD = 8'h00;
	localparam logic [7:0] OFF_DEAD_TIME = 8'h04;
	localparam logic [7:0] OFF_MIN_PULSE = 8'h08;
	localparam logic [7:0] OFF_SYNC_WIDTH = 8'h0c;
	localparam logic [7:0] OFF_DUTY_A = 8'h10;
	localparam logic [7:0] OFF_DUTY_B = 8'h14;
	localparam logic [7:0] OFF_DUTY_C = 8'h18;
	localparam logic [7:0] OFF_SEGMENT = 8'h1c;
	localparam logic [7:0] OFF_GATE_CHOP = 8'h20;
	localparam logic [7:0] OFF_MODE = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h28;
	localparam logic [7:0] OFF_SW_TRIP = 8'h2c;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_DOUBLE_BIT = 6;
	localparam int STAT_TRIP_BIT = 0;
	localparam int STAT_SHDN_BIT = 1;
	localparam int STAT_HALF_BIT = 3;
	localparam int SEG_XOVER_LSB = 6;
	localparam int GATE_HI_EN_BIT = 8;
	localparam int GATE_LO_EN_BIT = 9;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] RST_HALF_PERIOD = 16'h03e8;
	localparam logic [9:0] RST_DEAD_TIME = 10'h000;
	localparam logic [15:0] RST_MIN_PULSE = 16'h0000;
	localparam logic [7:0] RST_SYNC_WIDTH = 8'h27;
	localparam logic [15:0] RST_DUTY = 16'h0000;
	localparam logic [8:0] RST_SEGMENT = 9'h000;
	localparam logic [9:0] RST_GATE_CHOP = 10'h000;
endpackage : tcp_pkg

// ---- dv/tcp_gate_model.sv ----
// Gate drive model: source of the trip pin and watcher of each phase pair
`timescale 1ns/1ps
`default_nettype none
module tcp_gate_model (
	input wire logic clk,
	input wire logic clr,
	input wire logic tripReq,
	input wire logic [5:0] gates,
	output logic tripInN,
	output var int minGap,
	output var int shoot
);
	int gap = 0;
	int gapMin = 1000;
	int shootN = 0;
	// One process owns each count; the ports only mirror them
	assign minGap = gapMin;
	assign shoot = shootN;
	assign tripInN = ~tripReq;
	always @(posedge clk) begin
		if (clr) begin
			gapMin <= 1000;
		end else if (gates[0] | gates[1]) begin
			if (gap > 0 && gap < gapMin) begin
				gapMin <= gap;
			end
			gap <= 0;
		end else begin
			gap <= gap + 1;
		end
	end
	always @(posedge clk) begin
		if ((gates[0] & gates[1]) | (gates[2] & gates[3]) |
			(gates[4] & gates[5])) begin
			shootN <= shootN + 1;
		end
	end
endmodule : tcp_gate_model
`default_nettype wire

// ---- dv/tcp_pwm_test.sv ----
// Self-checking bench for the three-phase PWM block
`timescale 1ns/1ps
`default_nettype none
module tcp_pwm_test;
	logic clk = 0;
	logic nrst = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic tripReq = 0;
	logic clr = 0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, sync, syncIrq, tripIrq, tripInN;
	wire logic [5:0] g;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 97693;
	int sCnt = 0;
	int tCnt = 0;
	int minGap, shoot, tm, dt, w, duty, sIrq, sHi, lastIrq, tot;
	int hi[6], rise[6];

	always #2.5 clk = ~clk;

	tcp_pwm dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tripInN(tripInN),
		.phaseAHighOut(g[0]), .phaseALowOut(g[1]), .phaseBHighOut(g[2]),
		.phaseBLowOut(g[3]), .phaseCHighOut(g[4]), .phaseCLowOut(g[5]),
		.periodSyncPulse(sync), .syncIrq(syncIrq), .tripIrq(tripIrq));

	tcp_gate_model gm_u (.clk(clk), .clr(clr), .tripReq(tripReq), .gates(g),
		.tripInN(tripInN), .minGap(minGap), .shoot(shoot));

	// Interrupts are counted freely so that none slips between two tasks
	always @(posedge clk) begin
		cycles++;
		sCnt += syncIrq;
		tCnt += tripIrq;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task results();
		if (n_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task ok(input logic c);
		comparisons++;
		if (c !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, c, 1'b1);
		end
	endtask : ok

	function automatic logic near(input int a, input int b);
		return a >= b - 2 && a <= b + 2;
	endfunction : near

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(posedge clk);
		end
		if (k == 20) n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb

	task waitSync();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (syncIrq !== 1'b1 && k < 3000);
		if (k == 3000) n_errors++;
	endtask : waitSync

	task measure(input int n);
		logic [5:0] pg;
		pg = g;
		hi = '{default: 0};
		rise = '{default: 0};
		sIrq = 0;
		sHi = 0;
		lastIrq = 0;
		tot = 0;
		for (int i = 1; i <= n; i++) begin
			@(posedge clk);
			for (int j = 0; j < 6; j++) begin
				hi[j] += g[j];
				rise[j] += g[j] & ~pg[j];
				tot += g[j];
			end
			pg = g;
			sHi += sync;
			if (syncIrq === 1'b1) begin
				sIrq++;
				lastIrq = i;
			end
		end
	endtask : measure

	task cfg(input logic md, input logic [31:0] seg, input logic [31:0] gate,
		input int mp);
		apb(1, tcp_pkg::OFF_HALF_PERIOD, tm);
		apb(1, tcp_pkg::OFF_DEAD_TIME, dt);
		apb(1, tcp_pkg::OFF_MIN_PULSE, mp);
		apb(1, tcp_pkg::OFF_SYNC_WIDTH, w);
		apb(1, tcp_pkg::OFF_DUTY_A, duty);
		apb(1, tcp_pkg::OFF_DUTY_B, duty / 2);
		apb(1, tcp_pkg::OFF_SEGMENT, seg);
		apb(1, tcp_pkg::OFF_GATE_CHOP, gate);
		apb(1, tcp_pkg::OFF_MODE, {25'h0, md, 6'h0});
		waitSync();
		waitSync();
		waitSync();
	endtask : cfg

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int k;
		repeat (12) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		apb(0, tcp_pkg::OFF_SYNC_WIDTH, 0);
		cmp(rd, 32'h27);
		apb(0, tcp_pkg::OFF_MODE, 0);
		cmp(rd, 32'h0);
		apb(0, 8'h40, 0);
		ok(err === 1'b1);
		for (int i = 0; i < 7; i++) begin
			tm = $random(seed) & 32'hffff;
			apb(1, 8'(4 * i), tm);
			apb(0, 8'(4 * i), 0);
			cmp(rd, tm & (i == 1 ? 32'h3ff : i == 3 ? 32'hff : 32'hffff));
		end
		for (int c = 0; c < 7; c++) begin
			tm = 24 + ($random(seed) & 15);
			dt = 1 + ($random(seed) & 3);
			w = $random(seed) & 7;
			duty = c == 3 ? tm / 4 : tm / 2;
			case (c)
				1: cfg(1, 32'h3f, 0, 0);
				2: cfg(0, 32'h01, 0, 0);
				3: cfg(0, 32'h7f, 0, 0);
				4: cfg(0, 32'h3f, 32'h100 | ($random(seed) & 3), 0);
				5: cfg(0, 32'h3f, 32'h200 | ($random(seed) & 3), 0);
				6: cfg(0, 32'h3f, 0, duty + 1);
				default: cfg(0, 32'h3f, 0, 0);
			endcase
			if (c == 0) begin
				apb(0, tcp_pkg::OFF_STATUS, 0);
				ok(rd[3] === 1'b0);
				repeat (tm) @(posedge clk);
				apb(0, tcp_pkg::OFF_STATUS, 0);
				ok(rd[3] === 1'b1);
			end
			clr <= 1;
			waitSync();
			clr <= 0;
			measure(2 * tm);
			ok(sIrq == (c == 1 ? 2 : 1));
			ok(sHi == sIrq * (w + 1));
			ok(lastIrq == 2 * tm);
			case (c)
				2: ok(tot == hi[0] && hi[0] > 0);
				3: ok(near(hi[0], 2 * (tm - duty - dt)));
				4: ok(rise[0] > 1 && rise[1] == 1);
				5: ok(rise[1] > 1 && rise[0] == 1);
				6: ok(hi[0] + hi[1] == 0);
				default: begin
					ok(minGap == 2 * dt);
					ok(near(hi[0], 2 * (duty - dt)));
					ok(near(hi[1], 2 * (tm - duty - dt)));
					ok(near(hi[2], 2 * (duty / 2 - dt)));
				end
			endcase
		end
		cfg(0, 32'h3f, 0, 0);
		for (int j = 0; j < 300 && g[0] !== 1'b1; j++) @(posedge clk);
		k = tCnt;
		tripReq <= 1;
		#1;
		cmp({26'h0, g}, 32'h0);
		measure(8);
		ok(tCnt - k == 1 && tot == 0);
		apb(0, tcp_pkg::OFF_STATUS, 0);
		ok(rd[1:0] === 2'b10);
		tripReq <= 0;
		repeat (4) @(posedge clk);
		k = sCnt;
		apb(1, tcp_pkg::OFF_STATUS, 32'h2);
		measure(4);
		ok(sCnt - k == 1);
		apb(0, tcp_pkg::OFF_STATUS, 0);
		ok(rd[1:0] === 2'b01);
		for (int j = 0; j < 300 && g[0] !== 1'b1; j++) @(posedge clk);
		k = tCnt;
		apb(1, tcp_pkg::OFF_SW_TRIP, 32'h1);
		measure(8);
		ok(tCnt - k == 1);
		measure(8);
		ok(tot == 0);
		ok(shoot == 0);
		results();
	end
endmodule : tcp_pwm_test
`default_nettype wire
